// file: lcr_pkg.sv
// Purpose: Shared constants and types for the regulator and charger register slice.
// Assumes: Byte-wide registers reached over the two-wire serial port.
// Notes:   Struct layouts mirror the register bit order; a charger byte casts directly, the regulator control takes bits 7..1.
package lcr_pkg;

  // Register offsets
  localparam logic [7:0] LCR_OFF_LDO6_CTL  = 8'h61;
  localparam logic [7:0] LCR_OFF_LDO7_VSEL = 8'h64;
  localparam logic [7:0] LCR_OFF_LDO7_CTL  = 8'h65;
  localparam logic [7:0] LCR_OFF_CHG_RSVD  = 8'h70;
  localparam logic [7:0] LCR_OFF_CHG_CTL   = 8'h71;
  localparam logic [7:0] LCR_OFF_CHG_STAT  = 8'h78;
  localparam logic [7:0] LCR_OFF_CHG_IRQEN = 8'h79;

  // Field positions and widths
  localparam int LCR_VOLT_W      = 6;
  localparam int LCR_STAT_TMR    = 7;
  localparam int LCR_STAT_TEMP   = 6;
  localparam int LCR_STAT_IN     = 5;
  localparam int LCR_STAT_CHG    = 4;
  localparam int LCR_STAT_EXPIRE = 3;
  localparam int LCR_STAT_EOC    = 0;

  // Values after reset
  localparam logic [5:0] LCR_RST_VOLT  = 6'h00;
  localparam logic [6:0] LCR_RST_LDO   = 7'h00;
  localparam logic [7:0] LCR_RST_BYTE  = 8'h00;
  localparam logic [3:0] LCR_RST_NIB   = 4'h0;

  // Serial port: 7-bit bus address, arbitrary value
  localparam logic [6:0] LCR_DEV_ADDR  = 7'h2c;
  localparam logic [3:0] LCR_BITS_BYTE = 4'h8;

  typedef enum logic [3:0] {
    LCR_IDLE, LCR_ADDR, LCR_ADDR_ACK, LCR_PTR, LCR_PTR_ACK,
    LCR_WDATA, LCR_WDATA_ACK, LCR_RDATA, LCR_RDATA_ACK
  } lcr_bus_st_t;

  // Control byte of the seventh regulator, bits 7..1
  typedef struct packed {
    logic       on;
    logic       out_discharge_en;
    logic       low_quiescent_sel;
    logic [2:0] turn_on_delay;
    logic       fault_irq_allow;
  } lcr_ldo_ctl_t;

  typedef struct packed {
    logic       charge_hold;
    logic       rsvd;
    logic [1:0] total_timeout_sel;
    logic [1:0] precond_timeout_sel;
    logic [1:0] overvolt_thresh_sel;
  } lcr_chg_ctl_t;

  typedef struct packed {
    logic total_timeout_irq_en;
    logic temp_enter_irq_en;
    logic input_attach_irq_en;
    logic eoc_entry_irq_en;
    logic precharge_timeout_irq_en;
    logic temp_leave_irq_en;
    logic input_detach_irq_en;
    logic eoc_exit_irq_en;
  } lcr_irq_en_t;

  // Levels coming from the charger core
  typedef struct packed {
    logic total_timeout;
    logic precond_timeout;
    logic temp_in_range;
    logic supply_valid;
    logic eoc_reached;
  } lcr_chg_events_t;

  // Regulator controls as driven to the analog side
  typedef struct packed {
    logic [5:0] volt_code;
    logic       enable;
    logic       discharge_active;
    logic       low_quiescent_sel;
    logic [2:0] turn_on_delay;
  } lcr_ldo_drive_t;

endpackage

// file: lcr_regs.sv
// Purpose: Register slice for the seventh regulator and the battery charger.
// Assumes: scl/sda already clean and synchronous to clk; one clock domain.
// Notes:   sda is open drain: sda_out stays low, sda_oe pulls the line.
`timescale 1ns/1ps

module lcr_regs (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  input  wire logic                    ldo6_pgood,
  input  wire logic                    ldo7_pgood,
  input  wire logic                    ldo7_fault,
  input  wire lcr_pkg::lcr_chg_events_t chg_events,
  output lcr_pkg::lcr_ldo_drive_t       ldo7_drive,
  output logic                         ldo7_fault_irq,
  output lcr_pkg::lcr_chg_ctl_t         chg_ctl,
  output logic                         chg_irq
);
  import lcr_pkg::*;

  typedef struct packed {
    lcr_bus_st_t     st;
    logic            scl_q;
    logic            sda_q;
    logic [3:0]      bit_cnt;
    logic [7:0]      shift;
    logic [7:0]      tx;
    logic [7:0]      ptr;
    logic            rw;
    logic            nack;
    logic            sda_oe;
    logic [5:0]      volt;
    lcr_ldo_ctl_t    ldo;
    logic [7:0]      chg_rsvd;
    lcr_chg_ctl_t    chg;
    logic [3:0]      arm;
    logic [3:0]      pend;
    lcr_irq_en_t     irq_en;
    lcr_chg_events_t ev_prev;
    lcr_ldo_drive_t  drive;
    logic            fault_irq;
    logic            irq;
  } lcr_state_t;

  lcr_state_t s;
  lcr_state_t next_s;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       in_range;
  logic [7:0] rd_data;
  logic       rd_clr;
  logic       wr_en;
  logic [3:0] pend_set;
  logic [3:0] pend_clr;

  // Line edges and bus conditions against last sample
  assign scl_rise   = scl_in & ~s.scl_q;
  assign scl_fall   = ~scl_in & s.scl_q;
  assign start_seen = scl_in & s.scl_q & s.sda_q & ~sda_in;
  assign stop_seen  = scl_in & s.scl_q & ~s.sda_q & sda_in;

  assign in_range = chg_events.supply_valid;

  // Read data for the current pointer
  always_comb begin
    rd_data = 8'h00;
    case (s.ptr)
      LCR_OFF_LDO6_CTL:  rd_data = {7'h00, ldo6_pgood};
      LCR_OFF_LDO7_VSEL: rd_data = {2'b00, s.volt};
      LCR_OFF_LDO7_CTL:  rd_data = {s.ldo, ldo7_pgood};
      LCR_OFF_CHG_RSVD:  rd_data = s.chg_rsvd;
      LCR_OFF_CHG_CTL:   rd_data = s.chg;
      LCR_OFF_CHG_STAT: begin
        // marked bits masked when input out of range
        rd_data[LCR_STAT_TMR]  = s.pend[3] & in_range;
        rd_data[LCR_STAT_TEMP] = s.pend[2] & in_range;
        rd_data[LCR_STAT_IN]   = s.pend[1];
        rd_data[LCR_STAT_CHG]  = s.pend[0] & in_range;
        rd_data[LCR_STAT_EXPIRE] = in_range &
                                   (chg_events.total_timeout | chg_events.precond_timeout);
        rd_data[LCR_STAT_EOC] = in_range & chg_events.eoc_reached;
      end
      LCR_OFF_CHG_IRQEN: rd_data = s.irq_en;
      default:           rd_data = 8'h00;
    endcase
  end

  // Event detection from level edges of the charger core
  always_comb begin
    pend_set = 4'h0;
    // timer expiry needs arm and enable
    pend_set[3] = s.arm[3] & in_range &
                  ((chg_events.total_timeout & ~s.ev_prev.total_timeout &
                    s.irq_en.total_timeout_irq_en) |
                   (chg_events.precond_timeout & ~s.ev_prev.precond_timeout &
                    s.irq_en.precharge_timeout_irq_en));
    pend_set[2] = s.arm[2] & in_range &
                  ((chg_events.temp_in_range & ~s.ev_prev.temp_in_range &
                    s.irq_en.temp_enter_irq_en) |
                   (~chg_events.temp_in_range & s.ev_prev.temp_in_range &
                    s.irq_en.temp_leave_irq_en));
    pend_set[1] = s.arm[1] &
                  ((chg_events.supply_valid & ~s.ev_prev.supply_valid &
                    s.irq_en.input_attach_irq_en) |
                   (~chg_events.supply_valid & s.ev_prev.supply_valid &
                    s.irq_en.input_detach_irq_en));
    pend_set[0] = s.arm[0] & in_range &
                  ((chg_events.eoc_reached & ~s.ev_prev.eoc_reached &
                    s.irq_en.eoc_entry_irq_en) |
                   (~chg_events.eoc_reached & s.ev_prev.eoc_reached &
                    s.irq_en.eoc_exit_irq_en));
  end

  // Serial engine, register writes and status upkeep
  always_comb begin
    next_s   = s;
    wr_en    = 1'b0;
    rd_clr   = 1'b0;
    next_s.scl_q   = scl_in;
    next_s.sda_q   = sda_in;
    next_s.ev_prev = chg_events;

    if (start_seen) begin
      // Repeated start lands here too
      next_s.st      = LCR_ADDR;
      next_s.bit_cnt = 4'h0;
      next_s.sda_oe  = 1'b0;
    end else if (stop_seen) begin
      next_s.st     = LCR_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (s.st)
        LCR_ADDR, LCR_PTR, LCR_WDATA: begin
          next_s.shift   = {s.shift[6:0], sda_in};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
        end
        LCR_RDATA:     next_s.bit_cnt = s.bit_cnt + 4'h1;
        LCR_RDATA_ACK: next_s.nack = sda_in;
        default:       next_s.st = s.st;
      endcase
    end else if (scl_fall) begin
      case (s.st)
        LCR_ADDR: begin
          if (s.bit_cnt == LCR_BITS_BYTE) begin
            // Other addresses drop back to idle until next start
            if (s.shift[7:1] == LCR_DEV_ADDR) begin
              next_s.st     = LCR_ADDR_ACK;
              next_s.rw     = s.shift[0];
              next_s.sda_oe = 1'b1;
            end else begin
              next_s.st = LCR_IDLE;
            end
          end
        end
        LCR_ADDR_ACK: begin
          next_s.bit_cnt = 4'h0;
          if (s.rw) begin
            next_s.st     = LCR_RDATA;
            next_s.tx     = rd_data;
            next_s.sda_oe = ~rd_data[7];
            rd_clr        = (s.ptr == LCR_OFF_CHG_STAT);
          end else begin
            next_s.st     = LCR_PTR;
            next_s.sda_oe = 1'b0;
          end
        end
        LCR_PTR: begin
          if (s.bit_cnt == LCR_BITS_BYTE) begin
            next_s.ptr    = s.shift;
            next_s.st     = LCR_PTR_ACK;
            next_s.sda_oe = 1'b1;
          end
        end
        LCR_PTR_ACK, LCR_WDATA_ACK: begin
          next_s.st      = LCR_WDATA;
          next_s.bit_cnt = 4'h0;
          next_s.sda_oe  = 1'b0;
        end
        LCR_WDATA: begin
          if (s.bit_cnt == LCR_BITS_BYTE) begin
            wr_en         = 1'b1;
            next_s.ptr    = s.ptr + 8'h01;
            next_s.st     = LCR_WDATA_ACK;
            next_s.sda_oe = 1'b1;
          end
        end
        LCR_RDATA: begin
          if (s.bit_cnt == LCR_BITS_BYTE) begin
            // Release the line for the master's acknowledge
            next_s.st     = LCR_RDATA_ACK;
            next_s.sda_oe = 1'b0;
            next_s.ptr    = s.ptr + 8'h01;
          end else begin
            next_s.tx     = {s.tx[6:0], 1'b0};
            next_s.sda_oe = ~s.tx[6];
          end
        end
        LCR_RDATA_ACK: begin
          next_s.bit_cnt = 4'h0;
          if (s.nack) begin
            next_s.st = LCR_IDLE;
          end else begin
            next_s.st     = LCR_RDATA;
            next_s.tx     = rd_data;
            next_s.sda_oe = ~rd_data[7];
            rd_clr        = (s.ptr == LCR_OFF_CHG_STAT);
          end
        end
        default: next_s.st = LCR_IDLE;
      endcase
    end

    // Register writes at the end of a data byte
    if (wr_en) begin
      case (s.ptr)
        LCR_OFF_LDO7_VSEL: next_s.volt = s.shift[LCR_VOLT_W-1:0];
        // enable, delay and friends; power good bit ignored
        LCR_OFF_LDO7_CTL:  next_s.ldo = s.shift[7:1];
        LCR_OFF_CHG_RSVD:  next_s.chg_rsvd = s.shift;
        LCR_OFF_CHG_CTL:   next_s.chg = s.shift;
        // arm bits for each event group
        LCR_OFF_CHG_STAT:  next_s.arm = s.shift[7:4];
        LCR_OFF_CHG_IRQEN: next_s.irq_en = s.shift;
        default:           next_s.volt = s.volt;
      endcase
    end

    // Pending flags clear on status read; a fresh event wins over the clear
    pend_clr    = rd_clr ? 4'hf : 4'h0;
    next_s.pend = (s.pend & ~pend_clr) | pend_set;
    next_s.irq  = |next_s.pend;

    // Registered drive toward the regulator
    next_s.drive.volt_code         = next_s.volt;
    next_s.drive.enable            = next_s.ldo.on;
    next_s.drive.discharge_active  = next_s.ldo.out_discharge_en & ~next_s.ldo.on;
    next_s.drive.low_quiescent_sel = next_s.ldo.low_quiescent_sel;
    next_s.drive.turn_on_delay     = next_s.ldo.turn_on_delay;
    next_s.fault_irq = ldo7_fault & s.ldo.fault_irq_allow;
  end

  // State register; reset clears everything but the line samples scl_q and sda_q, which load high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s          <= '0;
      s.st       <= LCR_IDLE;
      s.scl_q    <= 1'b1;
      s.sda_q    <= 1'b1;
      s.volt     <= LCR_RST_VOLT;
      s.ldo      <= LCR_RST_LDO;
      s.chg_rsvd <= LCR_RST_BYTE;
      s.chg      <= LCR_RST_BYTE;
      s.irq_en   <= LCR_RST_BYTE;
      s.arm      <= LCR_RST_NIB;
      s.pend     <= LCR_RST_NIB;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register, except sda_out, which is tied low
  assign sda_out        = 1'b0;
  assign sda_oe         = s.sda_oe;
  assign ldo7_drive     = s.drive;
  assign ldo7_fault_irq = s.fault_irq;
  // hold bit drives the charger directly
  assign chg_ctl        = s.chg;
  assign chg_irq        = s.irq;

endmodule // lcr_regs

// file: lcr_regs_assertions.sv
// Purpose: Port-level checks on the regulator and charger register slice.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to lcr_regs; watches what the slice drives against the bus, fault and charger inputs.
`timescale 1ns/1ps

module lcr_regs_assertions
  import lcr_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic                     scl_in,
  input wire logic                     sda_in,
  input wire logic                     sda_out,
  input wire logic                     sda_oe,
  input wire logic                     ldo7_fault,
  input wire lcr_pkg::lcr_chg_events_t chg_events,
  input wire lcr_pkg::lcr_ldo_drive_t  ldo7_drive,
  input wire logic                     ldo7_fault_irq,
  input wire lcr_pkg::lcr_chg_ctl_t    chg_ctl,
  input wire logic                     chg_irq
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Serial clock fell one or two edges back
  sequence s_fell_near;
    ($past(scl_in, 2) && !$past(scl_in)) || ($past(scl_in, 3) && !$past(scl_in, 2));
  endsequence
  // Host start: data falls while clock high
  sequence s_host_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  // Some charger level moved lately
  sequence s_event_edge;
    ($past(chg_events) != $past(chg_events, 2)) || ($past(chg_events, 2) != $past(chg_events, 3));
  endsequence

  // Open drain: the data pin itself never goes high
  chk_sda_low_const: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  // Pull changes only just after a clock fall, so data never moves while scl high
  chk_oe_after_fall: assert property ($changed(sda_oe) |-> s_fell_near)
    else $error("sda_oe moved away from a clock fall");
  // Device must have let go of the line while the host makes a start
  chk_start_released: assert property (s_host_start |-> !sda_oe)
    else $error("sda pulled during host start");
  chk_ctl_lands_low: assert property ($changed(chg_ctl) |-> !$past(scl_in))
    else $error("chg_ctl changed outside a write");
  chk_drive_lands_low: assert property ($changed(ldo7_drive) |-> !$past(scl_in))
    else $error("ldo7_drive changed outside a write");
  chk_discharge_off: assert property (ldo7_drive.discharge_active |-> !ldo7_drive.enable)
    else $error("discharge while regulator on");
  chk_fault_gate: assert property (ldo7_fault_irq |-> $past(ldo7_fault))
    else $error("fault interrupt without fault");
  chk_irq_cause: assert property ($rose(chg_irq) |-> s_event_edge)
    else $error("charger interrupt without event");
endmodule // lcr_regs_assertions

bind lcr_regs lcr_regs_assertions u_lcr_regs_assertions (
  .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .ldo7_fault(ldo7_fault), .chg_events(chg_events),
  .ldo7_drive(ldo7_drive), .ldo7_fault_irq(ldo7_fault_irq), .chg_ctl(chg_ctl),
  .chg_irq(chg_irq)
);

// file: lcr_host_model.sv
// Purpose: Two-wire bus host that reaches the register slice.
// Assumes: sda_wire is the resolved line, pulled up when nobody pulls it.
// Notes:   Changes land on falling clk edges; eight cycles per bit, no stretching.
`timescale 1ns/1ps

module lcr_host_model (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  import lcr_pkg::*;

  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Wait some falling clk edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data moves three cycles after scl falls, to keep clear of start detection
  task automatic bit_io(input logic b, output logic seen);
    tick(1);
    sda_drv = b;
    tick(1);
    scl = 1'b1;
    tick(2);
    seen = sda_wire;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask

  // Start or repeated start
  task automatic start_cond;
    tick(1);
    sda_drv = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(2);
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask

  // Stop, then release
  task automatic stop_cond;
    tick(1);
    sda_drv = 1'b0;
    tick(1);
    scl = 1'b1;
    tick(2);
    sda_drv = 1'b1;
    tick(4);
  endtask

  // Byte out MSB first, then sample the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], seen);
    end
    bit_io(1'b1, seen);
    ack = !seen;
  endtask

  // Byte in with line released, then ack or nack
  task automatic recv_byte(output logic [7:0] b, input logic nack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, seen);
      b[i] = seen;
    end
    bit_io(nack, seen);
  endtask

  // Single-byte write; ok only if every byte was acked
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic a1, a2, a3;
    start_cond;
    send_byte({dev, 1'b0}, a1);
    send_byte(a, a2);
    send_byte(d, a3);
    stop_cond;
    ok = a1 && a2 && a3;
  endtask

  // Single-byte read through a repeated start
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic ak;
    start_cond;
    send_byte({LCR_DEV_ADDR, 1'b0}, ak);
    send_byte(a, ak);
    start_cond;
    send_byte({LCR_DEV_ADDR, 1'b1}, ak);
    recv_byte(d, 1'b1);
    stop_cond;
  endtask
endmodule // lcr_host_model

// file: ldo_and_charger_ctrl_regs_tb_top.sv
// Purpose: Self-checking bench for the regulator and charger register slice.
// Assumes: Host model drives the bus; the data line is pulled up.
// Notes:   A reference map predicts every readback but 0x78's, and the drive, control and fault outputs.
`timescale 1ns/1ps

module ldo_and_charger_ctrl_regs_tb_top;
  import lcr_pkg::*;
  logic            clk = 1'b0;
  logic            resetn = 1'b0;
  logic            scl, sda_drv, sda_oe, ok, p6, p7, flt, irq_f, irq_c;
  wire logic       sda_w = sda_drv & ~sda_oe;
  lcr_chg_events_t ev;
  lcr_ldo_drive_t  drv;
  lcr_chg_ctl_t    ctl;
  logic [7:0]      rdv;
  int              mdl [256];
  int              seed = 4;
  int              bad_count = 0;
  int              num_checks = 0;
  logic [7:0]      adr [7] = '{8'h61, 8'h64, 8'h65, 8'h70, 8'h71, 8'h79, 8'h7a};

  always #5 clk = ~clk;

  lcr_host_model u_lcr_host_model (.clk(clk), .sda_wire(sda_w), .scl(scl), .sda_drv(sda_drv));
  lcr_regs u_lcr_regs (
    .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
    .ldo6_pgood(p6), .ldo7_pgood(p7), .ldo7_fault(flt), .chg_events(ev),
    .ldo7_drive(drv), .ldo7_fault_irq(irq_f), .chg_ctl(ctl), .chg_irq(irq_c)
  );

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Readback the map should give; 0x78 is handled by its own scenario
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h61: return {7'h00, p6};
      8'h64: return {2'b00, mdl[a][5:0]};
      8'h65: return {mdl[a][7:1], p7};
      8'h70, 8'h71, 8'h79: return mdl[a][7:0];
      default: return 8'h00;
    endcase
  endfunction

  function automatic lcr_ldo_drive_t exp_drv();
    logic [7:0] c;
    c = mdl[8'h65][7:0];
    return {mdl[8'h64][5:0], c[7], c[6] & ~c[7], c[5], c[4:2]};
  endfunction

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_lcr_host_model.rd(a, rdv);
    check("read", {a, e}, {a, rdv});
  endtask

  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    u_lcr_host_model.wr(LCR_DEV_ADDR, a, d, ok);
    mdl[a] = int'(d);
    check("ack", 16'h1, {15'h0, ok});
  endtask

  // Charger level change, then let it settle
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask

  // Hang guard, well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    close_out;
  end

  initial begin
    // Supply in range, every other charger level low
    ev = 5'b00010;
    {p6, p7, flt} = 3'b000;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    check("drive", 16'h0, 16'(drv));
    foreach (adr[i]) rdchk(adr[i], exp_rd(adr[i]));
    // random map traffic, reserved and unmapped included
    for (int k = 0; k < 3; k++) begin
      foreach (adr[i]) begin
        {p6, p7, flt} = 3'($random(seed));
        wrm(adr[i], 8'($random(seed)));
        rdchk(adr[i], exp_rd(adr[i]));
        check("drive", 16'(exp_drv()), 16'(drv));
        check("ctl", 16'(mdl[8'h71][7:0]), 16'(ctl));
        check("fault", 16'(flt & mdl[8'h65][1]), 16'(irq_f));
      end
    end
    // second reset mid-run wipes what was written
    resetn = 1'b0;
    foreach (mdl[j]) mdl[j] = 0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    check("drive", 16'h0, 16'(drv));
    check("ctl", 16'h0, 16'(ctl));
    check("fault", 16'h0, 16'(irq_f));
    rdchk(8'h65, exp_rd(8'h65));
    // Foreign bus address: no ack, nothing written
    u_lcr_host_model.wr(LCR_DEV_ADDR ^ 7'h01, 8'h71, ~mdl[8'h71][7:0], ok);
    check("nack", 16'h0, {15'h0, ok});
    check("ctl", 16'(mdl[8'h71][7:0]), 16'(ctl));
    // enabled event with arm bits clear stays quiet
    wrm(8'h79, 8'hff);
    ev.eoc_reached = 1'b1;
    settle;
    check("irq", 16'h0, 16'(irq_c));
    rdchk(8'h78, 8'h01);
    ev.eoc_reached = 1'b0;
    settle;
    // enables on, all four flags armed
    wrm(8'h78, 8'hf0);
    ev.eoc_reached = 1'b1;
    settle;
    check("irq", 16'h1, 16'(irq_c));
    rdchk(8'h78, 8'h11);
    check("irq", 16'h0, 16'(irq_c));
    ev.total_timeout = 1'b1;
    settle;
    check("irq", 16'h1, 16'(irq_c));
    rdchk(8'h78, 8'h89);
    // event with enables off stays quiet
    wrm(8'h79, 8'h00);
    ev.temp_in_range = 1'b1;
    settle;
    rdchk(8'h78, 8'h09);
    check("irq", 16'h0, 16'(irq_c));
    // input leaves range, marked bits go invalid
    wrm(8'h79, 8'hff);
    ev.supply_valid = 1'b0;
    settle;
    check("irq", 16'h1, 16'(irq_c));
    rdchk(8'h78, 8'h20);
    ev.eoc_reached = 1'b0;
    settle;
    rdchk(8'h78, 8'h00);
    // input back in range, attach flagged
    ev.supply_valid = 1'b1;
    settle;
    check("irq", 16'h1, 16'(irq_c));
    rdchk(8'h78, 8'h28);
    // precharge timeout with temperature leaving range, one update
    ev = 5'b01010;
    settle;
    check("irq", 16'h1, 16'(irq_c));
    rdchk(8'h78, 8'hc8);
    ev.eoc_reached = 1'b1;
    settle;
    rdchk(8'h78, 8'h19);
    ev.eoc_reached = 1'b0;
    settle;
    check("irq", 16'h1, 16'(irq_c));
    rdchk(8'h78, 8'h18);
    check("irq", 16'h0, 16'(irq_c));
    close_out;
  end
endmodule // ldo_and_charger_ctrl_regs_tb_top
